// ### design/sssr_top.sv
/*
  synchronous serial slave port: apb register file, slave-clocked receiver
  with a two-character fifo and overrun handling, and slave transmitter with
  holding and shift registers.
  assumes: 50 mhz clk_i; clock and data pins arrive from another domain and
  are far slower (160 ns period in the bench); pad logic resolves pin levels.
*/
`include "sssr_consts.svh"

module sssr_top
  import sssr_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic clk_pin_i,
  output logic clk_pin_o,
  output logic clk_pin_oe_o,
  input wire logic data_pin_i,
  output logic data_pin_o,
  output logic data_pin_oe_o,
  output logic irq_o
);

  // ==========================================================
  // register state
  logic [7:0] transmit_status_control_q;   // transmit_status_control writable bits
  logic [7:0] rxsta_q;   // receive_status_control writable bits
  logic [7:0] baud_q;    // baud_control writable bits
  logic [7:0] divlo_q;   // baud_divisor_low, unused in slave mode
  logic [7:0] divhi_q;   // baud_divisor_high, unused in slave mode
  logic [2:0] inten_q;   // peripheral, transmit and receive enables
  sssr_apb_req_t req;    // bundled request

  assign req = '{addr: paddr_i, write: pwrite_i, wdata: pwdata_i};

  // derived mode bits
  logic port_enable, sync_mode, slave, rx_dir, continuous_receive_enable, single_receive_enable, rx9, tx9, transmit_enable_bit, clock_polarity_select;
  assign port_enable = rxsta_q[`SSSR_RX_PORT_ENABLE];
  assign sync_mode = transmit_status_control_q[`SSSR_TX_SYNC];
  assign slave = !transmit_status_control_q[`SSSR_TX_CLKMST];
  assign continuous_receive_enable = rxsta_q[`SSSR_RX_CONTINUOUS_RECEIVE_ENABLE];
  assign single_receive_enable = rxsta_q[`SSSR_RX_SINGLE_RECEIVE_ENABLE];
  assign rx9 = rxsta_q[`SSSR_RX_RX9];
  assign tx9 = transmit_status_control_q[`SSSR_TX_TX9];
  assign transmit_enable_bit = transmit_status_control_q[`SSSR_TX_TRANSMIT_ENABLE_BIT];
  assign clock_polarity_select = baud_q[`SSSR_BD_CLOCK_POLARITY_SELECT];

  logic active;  // port on in synchronous slave mode
  assign active = port_enable && sync_mode && slave;
  assign rx_dir = continuous_receive_enable || single_receive_enable;

  // ==========================================================
  // apb access decode, zero wait states
  logic wr_en, rd_en;
  assign wr_en = psel_i && penable_i && req.write;
  assign rd_en = psel_i && penable_i && !req.write;
  assign pready_o = 1'b1;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  logic mapped;  // any known offset
  assign mapped = hit(req.addr, `SSSR_OFF_TRANSMIT_STATUS_CONTROL) || hit(req.addr, `SSSR_OFF_RXSTA)
    || hit(req.addr, `SSSR_OFF_BAUD) || hit(req.addr, `SSSR_OFF_RXDATA)
    || hit(req.addr, `SSSR_OFF_TXDATA) || hit(req.addr, `SSSR_OFF_DIVLO)
    || hit(req.addr, `SSSR_OFF_DIVHI) || hit(req.addr, `SSSR_OFF_INTEN)
    || hit(req.addr, `SSSR_OFF_INTFLG);
  assign pslverr_o = psel_i && penable_i && !mapped;  // unmapped answers error

  logic rxdata_rd, txdata_wr;
  assign rxdata_rd = rd_en && hit(req.addr, `SSSR_OFF_RXDATA);
  assign txdata_wr = wr_en && hit(req.addr, `SSSR_OFF_TXDATA);

  // ==========================================================
  // pin synchroniser: three flops, a change counts once two and three agree
  logic [2:0] ck_sync_q, dt_sync_q;
  logic ck_stable_q, dt_stable_q;
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ck_sync_q <= 3'h0;
      dt_sync_q <= 3'h0;
    end
    else
    begin
      ck_sync_q <= {ck_sync_q[1:0], clk_pin_i};
      dt_sync_q <= {dt_sync_q[1:0], data_pin_i};
    end
  end

  // filtered levels; only stages two and three are looked at
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ck_stable_q <= 1'b0;
      dt_stable_q <= 1'b0;
    end
    else
    begin
      if (ck_sync_q[1] == ck_sync_q[2])
        ck_stable_q <= ck_sync_q[2];
      if (dt_sync_q[1] == dt_sync_q[2])
        dt_stable_q <= dt_sync_q[2];
    end
  end

  // edges in terms of the idle level; leading leaves idle, trailing returns.
  // an edge counts in the cycle that stages two and three agree on a new
  // level, one cycle before the filtered level follows; that saved cycle
  // puts a transmit bit on the pin before the trailing edge of a short half
  logic ck_agree, lead_edge, trail_edge, ck_norm, ck_prev_norm;
  assign ck_agree = (ck_sync_q[1] == ck_sync_q[2]);
  assign ck_norm = ck_sync_q[2] ^ clock_polarity_select;
  assign ck_prev_norm = ck_stable_q ^ clock_polarity_select;
  assign lead_edge = ck_agree && ck_norm && !ck_prev_norm;
  assign trail_edge = ck_agree && !ck_norm && ck_prev_norm;

  // ==========================================================
  // receiver: shift on trailing edge
  logic [8:0] rsr_q;   // receive_shift_register
  logic [3:0] rx_cnt_q;
  logic [3:0] rx_len;
  logic rx_done;
  logic overrun_error_flag_q;
  logic rx_run;
  assign rx_len = rx9 ? `SSSR_BITS9 : `SSSR_BITS8;
  assign rx_run = active && rx_dir && !overrun_error_flag_q;      // blocks reception
  assign rx_done = rx_run && trail_edge && (rx_cnt_q == rx_len - 4'h1);

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rsr_q <= 9'h000;
      rx_cnt_q <= 4'h0;
    end
    else if (!rx_run)
    begin
      // partial character discarded when reception stops
      rx_cnt_q <= 4'h0;
    end
    else if (trail_edge)
    begin
      // msb first per bit count, lsb arrives first on the line
      rsr_q <= {dt_stable_q, rsr_q[8:1]};
      rx_cnt_q <= rx_done ? 4'h0 : rx_cnt_q + 4'h1;
    end
  end

  // align the received word: eight-bit words sit one place too high
  logic [8:0] rx_word;
  assign rx_word = rx9 ? {dt_stable_q, rsr_q[8:1]} : {1'b0, dt_stable_q, rsr_q[8:2]};

  // ==========================================================
  // two-entry receive fifo, kept as an array
  sssr_char_t fifo_q [2];
  logic [1:0] fifo_cnt_q;
  logic fifo_rd_pop, fifo_push, ovr_event;
  assign fifo_rd_pop = rxdata_rd && (fifo_cnt_q != 2'h0);
  assign ovr_event = rx_done && (fifo_cnt_q == 2'h2) && !fifo_rd_pop;
  assign fifo_push = rx_done && !ovr_event;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      fifo_q[0] <= '0;
      fifo_q[1] <= '0;
      fifo_cnt_q <= 2'h0;
    end
    else if (!port_enable)
    begin
      // port disable empties the fifo
      fifo_cnt_q <= 2'h0;
    end
    else
    begin
      // overrun leaves both stored characters untouched
      case ({fifo_push, fifo_rd_pop})
        2'b10:
        begin
          fifo_q[fifo_cnt_q[0]] <= '{data: rx_word, framing_error_flag: 1'b0};
          fifo_cnt_q <= fifo_cnt_q + 2'h1;
        end
        2'b01:
        begin
          fifo_q[0] <= fifo_q[1];
          fifo_cnt_q <= fifo_cnt_q - 2'h1;
        end
        2'b11:
        begin
          // pop and push together: count unchanged
          if (fifo_cnt_q == 2'h1)
            fifo_q[0] <= '{data: rx_word, framing_error_flag: 1'b0};
          else
          begin
            fifo_q[0] <= fifo_q[1];
            fifo_q[1] <= '{data: rx_word, framing_error_flag: 1'b0};
          end
        end
        default:
        begin
          fifo_cnt_q <= fifo_cnt_q;
        end
      endcase
    end
  end

  // overrun flag: set wins over any clear in the same cycle
  logic ovr_cont_q;  // overrun happened under continuous receive
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      overrun_error_flag_q <= 1'b0;
      ovr_cont_q <= 1'b0;
    end
    else if (ovr_event)
    begin
      overrun_error_flag_q <= 1'b1;
      ovr_cont_q <= continuous_receive_enable;
    end
    else if (!port_enable)
      overrun_error_flag_q <= 1'b0;
    else if (ovr_cont_q && !continuous_receive_enable)
      overrun_error_flag_q <= 1'b0;
    else if (!ovr_cont_q && rxdata_rd)
      overrun_error_flag_q <= 1'b0;
  end

  // ==========================================================
  // transmitter: holding and shift registers
  logic [7:0] thr_q;      // transmit_holding_register
  logic thr_transmit_ninth_bit_q;       // ninth bit captured with the held word
  logic thr_full_q;
  logic [8:0] tsr_q;      // transmit_shift_register
  logic [3:0] tx_cnt_q;
  logic [3:0] tx_len_q;
  logic dout_q;
  sssr_tx_state_t tx_state_q;
  logic tx_run, tx_load, tx_last;
  assign tx_run = active && !rx_dir && transmit_enable_bit;
  assign tx_last = (tx_state_q == SSSR_TX_SHIFT) && trail_edge && (tx_cnt_q == tx_len_q);
  assign tx_load = tx_run && thr_full_q && ((tx_state_q == SSSR_TX_IDLE) || tx_last);

  // holding register; a write while the slot is full is dropped unless a load empties it in that cycle
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      thr_q <= `SSSR_RST_BYTE;
      thr_transmit_ninth_bit_q <= 1'b0;
      thr_full_q <= 1'b0;
    end
    else if (!port_enable)
      thr_full_q <= 1'b0;
    else if (txdata_wr && (!thr_full_q || tx_load))
    begin
      thr_q <= req.wdata[7:0];
      thr_transmit_ninth_bit_q <= transmit_status_control_q[`SSSR_TX_TRANSMIT_NINTH_BIT];
      thr_full_q <= 1'b1;                        // written word held until loaded
    end
    else if (tx_load)
      thr_full_q <= 1'b0;
  end

  // shift state machine: data changes on leading edge
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      tx_state_q <= SSSR_TX_IDLE;
      tsr_q <= 9'h000;
      tx_cnt_q <= 4'h0;
      tx_len_q <= `SSSR_BITS8;
      dout_q <= 1'b0;
    end
    else if (!tx_run)
    begin
      tx_state_q <= SSSR_TX_IDLE;
      tx_cnt_q <= 4'h0;
    end
    else
    begin
      case (tx_state_q)
        SSSR_TX_IDLE:
        begin
          if (tx_load)
          begin
            tsr_q <= {thr_transmit_ninth_bit_q, thr_q};           // first word moves at once
            tx_len_q <= tx9 ? `SSSR_BITS9 : `SSSR_BITS8;
            tx_cnt_q <= 4'h0;
            tx_state_q <= SSSR_TX_SHIFT;
          end
        end
        SSSR_TX_SHIFT:
        begin
          if (lead_edge)
          begin
            dout_q <= tsr_q[0];
            tsr_q <= {1'b0, tsr_q[8:1]};
            tx_cnt_q <= tx_cnt_q + 4'h1;
          end
          else if (tx_last)
          begin
            if (tx_load)
            begin
              tsr_q <= {thr_transmit_ninth_bit_q, thr_q};
              tx_len_q <= tx9 ? `SSSR_BITS9 : `SSSR_BITS8;
              tx_cnt_q <= 4'h0;
            end
            else
              tx_state_q <= SSSR_TX_IDLE;
          end
        end
        default:
        begin
          tx_state_q <= SSSR_TX_IDLE;
        end
      endcase
    end
  end

  // pins: the clock pin is never driven in slave mode
  assign clk_pin_o = 1'b0;
  assign clk_pin_oe_o = 1'b0;
  assign data_pin_o = dout_q;
  assign data_pin_oe_o = tx_run;

  // ==========================================================
  // flags and interrupt
  logic transmit_ready_flag, receive_complete_flag;
  assign transmit_ready_flag = !thr_full_q;
  assign receive_complete_flag = (fifo_cnt_q != 2'h0);
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      irq_o <= 1'b0;
    else
      irq_o <= inten_q[`SSSR_IE_PERIPHERAL_INTERRUPT_ENABLE] && ((transmit_ready_flag && inten_q[`SSSR_IE_TRANSMIT_INTERRUPT_ENABLE])
        || (receive_complete_flag && inten_q[`SSSR_IE_RECEIVE_INTERRUPT_ENABLE]));
  end

  // ==========================================================
  // register writes; single receive clears itself after a character
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      transmit_status_control_q <= `SSSR_RST_TRANSMIT_STATUS_CONTROL;
      rxsta_q <= `SSSR_RST_RXSTA;
      baud_q <= `SSSR_RST_BAUD;
      divlo_q <= `SSSR_RST_BYTE;
      divhi_q <= `SSSR_RST_BYTE;
      inten_q <= 3'h0;
    end
    else
    begin
      if (wr_en && hit(req.addr, `SSSR_OFF_TRANSMIT_STATUS_CONTROL))
        transmit_status_control_q <= req.wdata[7:0];
      if (wr_en && hit(req.addr, `SSSR_OFF_BAUD))
        baud_q <= req.wdata[7:0];
      if (wr_en && hit(req.addr, `SSSR_OFF_DIVLO))
        divlo_q <= req.wdata[7:0];
      if (wr_en && hit(req.addr, `SSSR_OFF_DIVHI))
        divhi_q <= req.wdata[7:0];
      if (wr_en && hit(req.addr, `SSSR_OFF_INTEN))
        inten_q <= req.wdata[2:0];
      if (wr_en && hit(req.addr, `SSSR_OFF_RXSTA))
        rxsta_q <= req.wdata[7:0];
      else if (rx_done && single_receive_enable)
        rxsta_q[`SSSR_RX_SINGLE_RECEIVE_ENABLE] <= 1'b0;
    end
  end

  // ==========================================================
  // read data mux, registered
  sssr_char_t top;
  assign top = fifo_q[0];
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    if (hit(req.addr, `SSSR_OFF_TRANSMIT_STATUS_CONTROL))
      rd_byte = {transmit_status_control_q[7:2], !(tx_state_q == SSSR_TX_SHIFT), transmit_status_control_q[0]};
    else if (hit(req.addr, `SSSR_OFF_RXSTA))
      rd_byte = {rxsta_q[7:3], top.framing_error_flag, overrun_error_flag_q, top.data[8]};
    else if (hit(req.addr, `SSSR_OFF_BAUD))
      rd_byte = {1'b0, !(rx_run && rx_cnt_q != 4'h0), baud_q[5:0]};
    else if (hit(req.addr, `SSSR_OFF_RXDATA))
      rd_byte = top.data[7:0];
    else if (hit(req.addr, `SSSR_OFF_TXDATA))
      rd_byte = thr_q;
    else if (hit(req.addr, `SSSR_OFF_DIVLO))
      rd_byte = divlo_q;
    else if (hit(req.addr, `SSSR_OFF_DIVHI))
      rd_byte = divhi_q;
    else if (hit(req.addr, `SSSR_OFF_INTEN))
      rd_byte = {5'h00, inten_q};
    else if (hit(req.addr, `SSSR_OFF_INTFLG))
      rd_byte = {6'h00, transmit_ready_flag, receive_complete_flag};
  end

  // data comes out of a flop in the setup cycle, valid by the access edge
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      prdata_o <= 32'h0000_0000;
    else if (psel_i && !penable_i)
      prdata_o <= {24'h00_0000, rd_byte};
  end

endmodule

// ### common/sssr_consts.svh
/*
  register offsets, field positions, reset values and character lengths for the
  synchronous serial slave block.
  assumes: included by bare name from the design file, the checker and the bench.
*/
`ifndef SSSR_CONSTS_SVH
`define SSSR_CONSTS_SVH

// ==========================================================
// register byte offsets on the apb bus
`define SSSR_OFF_TRANSMIT_STATUS_CONTROL 12'h000
`define SSSR_OFF_RXSTA 12'h004
`define SSSR_OFF_BAUD 12'h008
`define SSSR_OFF_RXDATA 12'h00c
`define SSSR_OFF_TXDATA 12'h010
`define SSSR_OFF_DIVLO 12'h014
`define SSSR_OFF_DIVHI 12'h018
`define SSSR_OFF_INTEN 12'h01c
`define SSSR_OFF_INTFLG 12'h020

// ==========================================================
// transmit_status_control fields
`define SSSR_TX_CLKMST 7
`define SSSR_TX_TX9 6
`define SSSR_TX_TRANSMIT_ENABLE_BIT 5
`define SSSR_TX_SYNC 4
`define SSSR_TX_HIGH_BAUD_SELECT 2
`define SSSR_TX_TRMT 1
`define SSSR_TX_TRANSMIT_NINTH_BIT 0

// receive_status_control fields
`define SSSR_RX_PORT_ENABLE 7
`define SSSR_RX_RX9 6
`define SSSR_RX_SINGLE_RECEIVE_ENABLE 5
`define SSSR_RX_CONTINUOUS_RECEIVE_ENABLE 4
`define SSSR_RX_FRAMING_ERROR_FLAG 2
`define SSSR_RX_OVERRUN_ERROR_FLAG 1
`define SSSR_RX_RECEIVED_NINTH_BIT 0

// baud_control fields
`define SSSR_BD_IDLE 6
`define SSSR_BD_CLOCK_POLARITY_SELECT 4
`define SSSR_BD_WIDE_DIVISOR_SELECT 3

// interrupt enable / flag fields
`define SSSR_IE_PERIPHERAL_INTERRUPT_ENABLE 2
`define SSSR_IE_TRANSMIT_INTERRUPT_ENABLE 1
`define SSSR_IE_RECEIVE_INTERRUPT_ENABLE 0
`define SSSR_IF_TRANSMIT_READY_FLAG 1
`define SSSR_IF_RECEIVE_COMPLETE_FLAG 0

// ==========================================================
// reset values
`define SSSR_RST_TRANSMIT_STATUS_CONTROL 8'h02
`define SSSR_RST_RXSTA 8'h00
`define SSSR_RST_BAUD 8'h00
`define SSSR_RST_BYTE 8'h00

// ==========================================================
// character lengths
`define SSSR_BITS8 4'h8
`define SSSR_BITS9 4'h9

`endif

// ### common/sssr_pkg.sv
/*
  types shared by the synchronous serial slave block.
  assumes: nothing beyond the constants header.
*/
package sssr_pkg;
  // ==========================================================
  // one stored character with its status
  typedef struct packed {
    logic [8:0] data;  // nine bits, msb is the ninth bit
    logic framing_error_flag;        // framing error, always clear in sync mode
  } sssr_char_t;

  // apb request as seen by the slave
  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [31:0] wdata;
  } sssr_apb_req_t;

  // transmitter states
  typedef enum logic [1:0] {
    SSSR_TX_IDLE,
    SSSR_TX_SHIFT
  } sssr_tx_state_t;
endpackage

// ### verif/sssr_assertions.sv
/*
  checker for the serial slave top: bus phases, pin drivers,
  interrupt gating and transmit bit timing.
  assumes: bound to sssr_top; control bits are followed off apb writes.
*/
`include "sssr_consts.svh"

module sssr_checker
  import sssr_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic clk_pin_i,
  input wire logic clk_pin_o,
  input wire logic clk_pin_oe_o,
  input wire logic data_pin_i,
  input wire logic data_pin_o,
  input wire logic data_pin_oe_o,
  input wire logic irq_o
);
  // ==========================================================
  // shadow control bits
  logic continuous_receive_enable_q; // continuous receive as last written
  logic port_enable_q; // port enable
  logic txok_q; // sync slave with transmit enabled
  logic ie_q; // some interrupt source enabled
  logic clock_polarity_select_q; // clock idle level
  logic tx_ok; // port may drive the data pin
  logic wr_acc; // a write lands at this edge
  assign wr_acc = psel_i && penable_i && pwrite_i && pready_o;
  assign tx_ok = port_enable_q && txok_q;

  // follow writes only; status and self-clearing bits are not needed
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      continuous_receive_enable_q <= 1'b0;
      port_enable_q <= 1'b0;
      txok_q <= 1'b0;
      ie_q <= 1'b0;
      clock_polarity_select_q <= 1'b0;
    end
    else if (wr_acc)
    begin
      case (paddr_i)
        `SSSR_OFF_TRANSMIT_STATUS_CONTROL: txok_q <= pwdata_i[5] && pwdata_i[4] && !pwdata_i[7];
        `SSSR_OFF_RXSTA:
        begin
          continuous_receive_enable_q <= pwdata_i[`SSSR_RX_CONTINUOUS_RECEIVE_ENABLE];
          port_enable_q <= pwdata_i[`SSSR_RX_PORT_ENABLE];
        end
        `SSSR_OFF_BAUD: clock_polarity_select_q <= pwdata_i[`SSSR_BD_CLOCK_POLARITY_SELECT];
        `SSSR_OFF_INTEN: ie_q <= pwdata_i[1] || pwdata_i[0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_clk_driver_off: assert property (!clk_pin_oe_o && !clk_pin_o)
    else $error("slave drives its clock pin");
  a_err_phase: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("error response outside access phase");
  a_err_unmapped: assert property (psel_i && penable_i && paddr_i > 12'h020 |-> pslverr_o)
    else $error("unmapped access not refused");
  a_read_hold: assert property (psel_i && penable_i |=> $stable(prdata_o))
    else $error("read data moved after access");
  a_oe_receive: assert property (continuous_receive_enable_q && $past(continuous_receive_enable_q) |-> !data_pin_oe_o)
    else $error("data pin driven while receiving");
  a_oe_enable: assert property (data_pin_oe_o |-> tx_ok || $past(tx_ok))
    else $error("data pin driven while port not set to transmit");
  a_irq_gated: assert property (irq_o |-> $past(ie_q))
    else $error("interrupt with all sources masked");
  a_tx_hold_trail: assert property (data_pin_oe_o && $changed(clk_pin_i)
    && clk_pin_i == clock_polarity_select_q |=> $stable(data_pin_o)[*3])
    else $error("transmit bit moved at trailing edge");
endmodule

bind sssr_top sssr_checker u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .clk_pin_i(clk_pin_i),
  .clk_pin_o(clk_pin_o), .clk_pin_oe_o(clk_pin_oe_o), .data_pin_i(data_pin_i),
  .data_pin_o(data_pin_o), .data_pin_oe_o(data_pin_oe_o), .irq_o(irq_o)
);

// ### verif/sssr_master_model.sv
/*
  far-side master of the synchronous link: makes the shift clock,
  drives receive data and captures what the slave sends.
  assumes: called by task from the bench; 160 ns link period.
*/
module sssr_master (
  output logic sck_o,
  output logic sdo_o,
  input wire logic sdi_i
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 80; // half of the link period

  // clock stands still between frames
  initial
  begin
    sck_o = 1'b0;
    sdo_o = 1'b0;
  end

  // park the clock at a new idle level; odd offset keeps it off clk_i edges
  task automatic idle(input logic pol);
    #7;
    sck_o = pol;
    #(HALF);
  endtask

  // one frame of n bits, lsb first, exactly n clocks
  task automatic xfer(input logic [8:0] tx, input int n, input logic pol,
                      output logic [8:0] rx);
    rx = 9'h000;
    #7;
    for (int i = 0; i < n; i++)
    begin
      sck_o = !pol;
      sdo_o = tx[i];
      #(HALF);
      sck_o = pol;
      rx[i] = sdi_i;
      #(HALF);
    end
    sdo_o = !sdo_o; // inverted: never leave a stale level behind
  endtask
endmodule

// ### verif/sync_serial_slave_and_rx_tb.sv
/*
  self-checking bench for the serial slave: receive rows, overrun in
  both receive modes, and slave transmit with a held character.
  assumes: sssr_top with the apb map of the constants header.
*/
`include "sssr_consts.svh"

module sync_serial_slave_and_rx_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  typedef struct packed {
    logic rx9; // nine-bit frame
    logic pol; // clock idle level
    logic [8:0] ch; // character sent by the master
  } sssr_row_t;
  sssr_row_t rows [4] = '{'{1'b0, 1'b1, 9'h0a5}, '{1'b1, 1'b1, 9'h1c3},
                          '{1'b1, 1'b0, 9'h03c}, '{1'b0, 1'b0, 9'h05a}};
  logic [7:0] seq [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
  logic clk_i, reset_i, psel_i, penable_i, pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, v;
  logic pready_o, pslverr_o, clk_pin_o, clk_pin_oe_o;
  logic data_pin_o, data_pin_oe_o, irq_o, m_sck, m_sdo, slv;
  wire ck, dt; // resolved pin levels
  logic [8:0] got;
  int err_count;
  int checks;
  assign ck = clk_pin_oe_o ? clk_pin_o : m_sck;
  assign dt = data_pin_oe_o ? data_pin_o : m_sdo;

  sssr_top dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .clk_pin_i(ck), .clk_pin_o(clk_pin_o),
    .clk_pin_oe_o(clk_pin_oe_o), .data_pin_i(dt), .data_pin_o(data_pin_o),
    .data_pin_oe_o(data_pin_oe_o), .irq_o(irq_o));
  sssr_master m (.sck_o(m_sck), .sdo_o(m_sdo), .sdi_i(dt));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = !clk_i;
  end

  // ==========================================================
  // checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic stop_wait();
    err_count++;
    $display("wrong value at %0t: wait ran out", $time);
    report_and_stop();
  endtask

  // ==========================================================
  // apb master: hold the request until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= {24'h000000, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 40);
    if (pready_o !== 1'b1)
      stop_wait();
    q = prdata_o;
    slv = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    apb(1'b0, a, 8'h00, q);
  endtask

  // status is read until the masked bits leave the given value
  task automatic poll(input logic [7:0] msk, input logic [7:0] c, output logic [31:0] q);
    int n;
    n = 0;
    do
    begin
      rd(`SSSR_OFF_RXSTA, q);
      n++;
    end
    while ((q[7:0] & msk) == c && n < 60);
    if ((q[7:0] & msk) == c)
      stop_wait();
  endtask

  // sampled between edges so the registered request has settled
  task automatic wait_irq(input logic e);
    int n;
    n = 0;
    while (irq_o !== e && n < 60)
    begin
      @(negedge clk_i);
      n++;
    end
    if (irq_o !== e)
      stop_wait();
    checks++;
    @(posedge clk_i);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= '0;
    reset_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd(`SSSR_OFF_TRANSMIT_STATUS_CONTROL, v); chk(v, 32'h02);
    rd(`SSSR_OFF_RXSTA, v); chk(v, 32'h00);
    rd(12'h040, v); chk({v, slv}, 33'h1);
    wr(`SSSR_OFF_TRANSMIT_STATUS_CONTROL, 8'h10);
    wr(`SSSR_OFF_INTEN, 8'h05); // peripheral and receive enables
    // ordinary receive cases, one frame per row
    foreach (rows[i])
    begin
      wr(`SSSR_OFF_RXSTA, 8'h00);
      m.idle(rows[i].pol);
      wr(`SSSR_OFF_BAUD, {3'h0, rows[i].pol, 4'h0});
      wr(`SSSR_OFF_RXSTA, {1'b1, rows[i].rx9, 6'h10});
      m.xfer(rows[i].ch, rows[i].rx9 ? 9 : 8, rows[i].pol, got);
      wait_irq(1'b1);
      rd(`SSSR_OFF_RXSTA, v);
      if (rows[i].rx9) chk(v[0], rows[i].ch[8]);
      rd(`SSSR_OFF_RXDATA, v); chk(v, rows[i].ch[7:0]);
      wait_irq(1'b0);
    end
    // overrun with continuous receive: a data read leaves it, clearing continuous_receive_enable clears it
    for (int k = 0; k < 3; k++) m.xfer({1'b0, seq[k]}, 8, 1'b0, got);
    poll(8'h02, 8'h00, v); chk(v[1], 1'b1);
    rd(`SSSR_OFF_RXDATA, v); chk(v, seq[0]);
    rd(`SSSR_OFF_RXSTA, v); chk(v[1], 1'b1);
    m.xfer({1'b0, seq[3]}, 8, 1'b0, got);
    rd(`SSSR_OFF_RXDATA, v); chk(v, seq[1]);
    rd(`SSSR_OFF_INTFLG, v); chk(v[0], 1'b0);
    wr(`SSSR_OFF_RXSTA, 8'h80);
    rd(`SSSR_OFF_RXSTA, v); chk(v, 32'h80);
    // overrun with single receive: a data read clears it
    for (int k = 0; k < 3; k++)
    begin
      wr(`SSSR_OFF_RXSTA, 8'ha0);
      m.xfer({1'b0, seq[k]}, 8, 1'b0, got);
      poll(8'h22, 8'h20, v);
    end
    chk(v[1], 1'b1);
    rd(`SSSR_OFF_RXDATA, v); chk(v, seq[0]);
    rd(`SSSR_OFF_RXSTA, v); chk(v[1], 1'b0);
    rd(`SSSR_OFF_RXDATA, v); chk(v, seq[1]);
    // slave transmit: first byte to the shifter, second held
    wr(`SSSR_OFF_TRANSMIT_STATUS_CONTROL, 8'h30);
    wr(`SSSR_OFF_INTEN, 8'h06);
    wr(`SSSR_OFF_TXDATA, 8'h96);
    wr(`SSSR_OFF_TXDATA, 8'h3c);
    rd(`SSSR_OFF_INTFLG, v); chk(v[1], 1'b0);
    chk({data_pin_oe_o, irq_o}, 2'h2);
    m.xfer(9'h000, 8, 1'b0, got); chk(got, 9'h096);
    wait_irq(1'b1);
    rd(`SSSR_OFF_INTFLG, v); chk(v[1], 1'b1);
    m.xfer(9'h000, 8, 1'b0, got); chk(got, 9'h03c);
    chk(clk_pin_oe_o, 1'b0);
    report_and_stop();
  end
endmodule
